// >>> hw/crf_pkg.sv
// package of constants and carriers for the cpu register file block
`default_nettype none
package crf_pkg;
	localparam int unsigned NUM_REGS = 32;
	localparam int unsigned REG_W = 8;
	localparam int unsigned RIDX_W = 5;
	localparam int unsigned ADDR_W = 16;
	localparam logic [4:0] UPPER_BASE = 5'h10;
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;
	localparam logic [4:0] MUL_LO = 5'h00;
	localparam logic [4:0] MUL_HI = 5'h01;
	localparam logic [15:0] REG_SPACE_END = 16'h001f;
	localparam logic [15:0] SRAM_BASE = 16'h0060;
	localparam logic [15:0] SRAM_END_4K = 16'h0fff;
	localparam logic [15:0] SRAM_END_8K = 16'h1fff;
	localparam logic [15:0] SRAM_END_12K = 16'h2fff;
	localparam logic [15:0] SRAM_END_16K = 16'h3fff;
	localparam logic [5:0] DISP_MAX = 6'h3f;
	localparam logic [2:0] BIT_MAX = 3'h7;
	localparam int unsigned SRAM_WORDS = 16384;
	localparam int unsigned SRAM_ACCESS_CYCLES = 2;

	typedef enum logic [1:0] {CRF_SIZE_4K, CRF_SIZE_8K, CRF_SIZE_12K, CRF_SIZE_16K} crf_size_type;
	typedef enum logic [2:0] {CRF_OP_NONE, CRF_OP_ALU, CRF_OP_IMM, CRF_OP_MUL_UU, CRF_OP_MUL_RS} crf_op_type;
	typedef enum logic [1:0] {CRF_PTR_X, CRF_PTR_Y, CRF_PTR_Z} crf_ptr_type;

	// one instruction issue from the decoder
	typedef struct packed {
		crf_op_type op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic wr_en;
		logic [7:0] wr_data;
	} crf_issue_type;

	// one data-space access; address from a pointer plus displacement
	typedef struct packed {
		logic valid;
		logic write;
		crf_ptr_type ptr;
		logic [5:0] disp;
		logic [7:0] wdata;
	} crf_mem_type;

	typedef struct packed {
		logic n;
		logic v;
	} crf_flags_type;
endpackage
`default_nettype wire

// >>> hw/crf_top.sv
// general-purpose register file with data-space window and multiply result pair
`default_nettype none
module crf_top #(
	parameter int unsigned SRAM_DEPTH = crf_pkg::SRAM_WORDS
) (
	input wire logic clk_sys_in, // system clock
	input wire logic rstn_in, // async reset, active low
	input wire crf_pkg::crf_size_type size_in, // configured sram size
	input wire crf_pkg::crf_issue_type issue_in, // decoder issue
	input wire logic [15:0] mul_product_in, // product from multiplier
	input wire crf_pkg::crf_mem_type mem_in, // indirect access request
	input wire crf_pkg::crf_flags_type flags_in, // n and v from alu
	input wire logic [2:0] bit_sel_in, // bit position select
	output logic [7:0] rd_data_out, // destination operand
	output logic [7:0] rr_data_out, // source operand
	output logic issue_err_out, // illegal operand register
	output logic [7:0] mem_rdata_out, // indirect read data
	output logic mem_done_out, // access complete pulse
	output logic mem_hit_out, // access landed in storage
	output logic sign_flag_out, // signed-test flag
	output logic bit_val_out // selected bit of rd
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rd_data;
		logic [7:0] rr_data;
		logic issue_err;
		logic mul_pend;
		logic mem_busy;
		logic mem_write;
		logic mem_is_reg;
		logic mem_is_ram;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
		logic [7:0] mem_rdata;
		logic mem_done;
		logic mem_hit;
		logic sign_flag;
		logic bit_val;
	} crf_state_type;

	crf_state_type st_r;
	crf_state_type st_nxt;
	logic [7:0] regs_r [crf_pkg::NUM_REGS];
	logic [7:0] sram_r [SRAM_DEPTH];

	function automatic logic [15:0] sram_end(input crf_pkg::crf_size_type sz);
		case (sz)
			crf_pkg::CRF_SIZE_4K: sram_end = crf_pkg::SRAM_END_4K;
			crf_pkg::CRF_SIZE_8K: sram_end = crf_pkg::SRAM_END_8K;
			crf_pkg::CRF_SIZE_12K: sram_end = crf_pkg::SRAM_END_12K;
			default: sram_end = crf_pkg::SRAM_END_16K;
		endcase
	endfunction

	function automatic logic [4:0] ptr_lo(input crf_pkg::crf_ptr_type p);
		case (p)
			crf_pkg::CRF_PTR_X: ptr_lo = crf_pkg::PTR_X_LO;
			crf_pkg::CRF_PTR_Y: ptr_lo = crf_pkg::PTR_Y_LO;
			default: ptr_lo = crf_pkg::PTR_Z_LO;
		endcase
	endfunction

	function automatic logic is_mul(input crf_pkg::crf_op_type op);
		is_mul = (op == crf_pkg::CRF_OP_MUL_UU) || (op == crf_pkg::CRF_OP_MUL_RS);
	endfunction

	// restricted operand subsets live in the upper half of the file
	function automatic logic in_upper(input logic [4:0] r);
		in_upper = r >= crf_pkg::UPPER_BASE;
	endfunction

	// ---------------------------------------------------------------
	// operand checks and pointer address
	// ---------------------------------------------------------------
	logic imm_bad;
	logic mul_bad;
	logic issue_bad;
	logic [4:0] plo;
	logic [15:0] ptr_val;
	logic [15:0] eff_addr;
	logic reg_write_direct;
	logic mem_take;

	always_comb
	begin
		imm_bad = (issue_in.op == crf_pkg::CRF_OP_IMM) && (issue_in.rd < crf_pkg::UPPER_BASE);
		// restricted multiplies draw both operands from the upper half
		mul_bad = (issue_in.op == crf_pkg::CRF_OP_MUL_RS) &&
			((issue_in.rd < crf_pkg::UPPER_BASE) || (issue_in.rr < crf_pkg::UPPER_BASE));
		issue_bad = imm_bad || mul_bad;
		plo = ptr_lo(mem_in.ptr);
		ptr_val = {regs_r[plo + 5'h01], regs_r[plo]};
		eff_addr = ptr_val + {10'h000, mem_in.disp};
		mem_take = mem_in.valid && !st_r.mem_busy;
		// alu and immediate writes; multiplies use the pair instead
		reg_write_direct = issue_in.wr_en && !issue_bad &&
			(issue_in.op == crf_pkg::CRF_OP_ALU || issue_in.op == crf_pkg::CRF_OP_IMM);
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.mem_done = 1'b0;
		st_nxt.rd_data = regs_r[issue_in.rd];
		st_nxt.rr_data = regs_r[issue_in.rr];
		st_nxt.issue_err = issue_bad;
		st_nxt.sign_flag = flags_in.n ^ flags_in.v;
		st_nxt.bit_val = regs_r[issue_in.rd][bit_sel_in];
		st_nxt.mul_pend = is_mul(issue_in.op) && !issue_bad;
		if (st_r.mem_busy)
		begin
			// second cycle of the two-cycle access
			st_nxt.mem_busy = 1'b0;
			st_nxt.mem_done = 1'b1;
			st_nxt.mem_hit = st_r.mem_is_reg || st_r.mem_is_ram;
			if (st_r.mem_is_reg)
				st_nxt.mem_rdata = regs_r[st_r.mem_addr[4:0]];
			else if (st_r.mem_is_ram)
				st_nxt.mem_rdata = sram_r[st_r.mem_addr[13:0]];
			else
				st_nxt.mem_rdata = 8'h00;
		end
		else if (mem_in.valid)
		begin
			st_nxt.mem_busy = 1'b1;
			st_nxt.mem_write = mem_in.write;
			st_nxt.mem_addr = eff_addr;
			st_nxt.mem_wdata = mem_in.wdata;
			st_nxt.mem_is_reg = eff_addr <= crf_pkg::REG_SPACE_END;
			st_nxt.mem_is_ram = eff_addr >= crf_pkg::SRAM_BASE && eff_addr <= sram_end(size_in);
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rstn_in)
	begin
		if (!rstn_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// storage has no reset; contents are undefined until written
	always_ff @(posedge clk_sys_in)
	begin
		if (reg_write_direct)
			regs_r[issue_in.rd] <= issue_in.wr_data;
		if (st_r.mul_pend)
		begin
			regs_r[crf_pkg::MUL_HI] <= mul_product_in[15:8];
			regs_r[crf_pkg::MUL_LO] <= mul_product_in[7:0];
		end
		// data-space write lands in the same storage as direct writes
		if (st_r.mem_busy && st_r.mem_write && st_r.mem_is_reg)
			regs_r[st_r.mem_addr[4:0]] <= st_r.mem_wdata;
		if (st_r.mem_busy && st_r.mem_write && st_r.mem_is_ram)
			sram_r[st_r.mem_addr[13:0]] <= st_r.mem_wdata;
	end

	assign rd_data_out = st_r.rd_data;
	assign rr_data_out = st_r.rr_data;
	assign issue_err_out = st_r.issue_err;
	assign mem_rdata_out = st_r.mem_rdata;
	assign mem_done_out = st_r.mem_done;
	assign mem_hit_out = st_r.mem_hit;
	assign sign_flag_out = st_r.sign_flag;
	assign bit_val_out = st_r.bit_val;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_imm_low_dest: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_IMM && issue_in.rd < crf_pkg::UPPER_BASE) |=> issue_err_out)
		else $error("immediate op to low register not flagged");
	chk_alu_any_reg: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_ALU) |=> !issue_err_out)
		else $error("register op wrongly refused");
	chk_access_two_cycles: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_in.valid && !st_r.mem_busy) |=> !mem_done_out ##1 mem_done_out)
		else $error("data access not two cycles");
	chk_beyond_no_hit: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_in.valid && !st_r.mem_busy && eff_addr > sram_end(size_in)) |=> ##1 !mem_hit_out)
		else $error("access beyond sram hit storage");
	chk_sram_base_hit: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_in.valid && !st_r.mem_busy && eff_addr == crf_pkg::SRAM_BASE) |=> ##1 mem_hit_out)
		else $error("sram base not mapped");
	chk_sign_flag_xor: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		1'b1 |=> sign_flag_out == ($past(flags_in.n) ^ $past(flags_in.v)))
		else $error("signed flag not n xor v");
	chk_mul_pair_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_UU) |=> ##1 regs_r[crf_pkg::MUL_LO] == $past(mul_product_in[7:0]))
		else $error("multiply low byte not in register zero");
	chk_alu_writeback: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(reg_write_direct && !st_r.mul_pend && !st_r.mem_busy) |=> regs_r[$past(issue_in.rd)] == $past(issue_in.wr_data))
		else $error("alu result not written in one cycle");
	chk_reg_window_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(st_r.mem_busy && st_r.mem_is_reg && !st_r.mem_write) |=> mem_hit_out && mem_done_out)
		else $error("register window read missed");

	// ---------------------------------------------------------------
	// operand and multiply checks
	// ---------------------------------------------------------------
	chk_plain_op_ok: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_NONE) |=> !issue_err_out)
		else $error("single register op wrongly refused");
	chk_imm_upper_ok: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_IMM && in_upper(issue_in.rd)) |=> !issue_err_out)
		else $error("immediate op to upper register refused");
	chk_imm_no_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_IMM && !in_upper(issue_in.rd) && !st_r.mul_pend && !st_r.mem_busy)
		|=> regs_r[$past(issue_in.rd)] == $past(regs_r[issue_in.rd]))
		else $error("refused immediate op changed its register");
	chk_rs_low_refused: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_RS && !(in_upper(issue_in.rd) && in_upper(issue_in.rr)))
		|=> issue_err_out)
		else $error("restricted multiply on low register not flagged");
	chk_rs_upper_ok: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_RS && in_upper(issue_in.rd) && in_upper(issue_in.rr))
		|=> !issue_err_out)
		else $error("restricted multiply on upper registers refused");
	chk_uu_any_reg: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_UU) |=> !issue_err_out)
		else $error("unsigned multiply wrongly refused");
	chk_refused_mul_keeps: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_RS && issue_bad && !st_r.mul_pend && !st_r.mem_busy && !mem_take)
		|=> ##1 regs_r[crf_pkg::MUL_LO] == $past(regs_r[crf_pkg::MUL_LO], 2))
		else $error("refused multiply wrote the result pair");
	chk_mul_pair_high: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_UU) |=> ##1 regs_r[crf_pkg::MUL_HI] == $past(mul_product_in[15:8]))
		else $error("multiply high byte not in register one");
	chk_rs_pair_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(issue_in.op == crf_pkg::CRF_OP_MUL_RS && in_upper(issue_in.rd) && in_upper(issue_in.rr))
		|=> ##1 regs_r[crf_pkg::MUL_LO] == $past(mul_product_in[7:0]))
		else $error("restricted multiply product not in register zero");
	chk_mul_operand_fetch: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		is_mul(issue_in.op) |=> rd_data_out == $past(regs_r[issue_in.rd]) &&
			rr_data_out == $past(regs_r[issue_in.rr]))
		else $error("multiply operands not fetched in first cycle");

	// ---------------------------------------------------------------
	// data space checks
	// ---------------------------------------------------------------
	chk_ptr_x_pair: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_take && mem_in.ptr == crf_pkg::CRF_PTR_X) |=> st_r.mem_addr ==
			$past({regs_r[crf_pkg::PTR_X_LO + 5'h01], regs_r[crf_pkg::PTR_X_LO]}) + $past({10'h000, mem_in.disp}))
		else $error("pointer x not formed from its register pair");
	chk_ptr_y_pair: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_take && mem_in.ptr == crf_pkg::CRF_PTR_Y) |=> st_r.mem_addr ==
			$past({regs_r[crf_pkg::PTR_Y_LO + 5'h01], regs_r[crf_pkg::PTR_Y_LO]}) + $past({10'h000, mem_in.disp}))
		else $error("pointer y not formed from its register pair");
	chk_ptr_z_pair: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_take && mem_in.ptr == crf_pkg::CRF_PTR_Z) |=> st_r.mem_addr ==
			$past({regs_r[crf_pkg::PTR_Z_LO + 5'h01], regs_r[crf_pkg::PTR_Z_LO]}) + $past({10'h000, mem_in.disp}))
		else $error("pointer z not formed from its register pair");
	chk_reg_space_map: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_take && eff_addr <= crf_pkg::REG_SPACE_END) |=> ##1 mem_hit_out)
		else $error("register address not mapped");
	chk_window_read_data: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(st_r.mem_busy && st_r.mem_is_reg && !st_r.mem_write) |=> mem_rdata_out == $past(regs_r[st_r.mem_addr[4:0]]))
		else $error("register window read wrong data");
	chk_window_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(st_r.mem_busy && st_r.mem_write && st_r.mem_is_reg)
		|=> regs_r[$past(st_r.mem_addr[4:0])] == $past(st_r.mem_wdata))
		else $error("data space write missed register storage");
	chk_io_gap_miss: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_take && eff_addr > crf_pkg::REG_SPACE_END && eff_addr < crf_pkg::SRAM_BASE)
		|=> ##1 !mem_hit_out)
		else $error("address below sram base hit storage");
	chk_sram_end_hit: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mem_take && eff_addr == sram_end(size_in)) |=> ##1 mem_hit_out)
		else $error("last sram address not mapped");
	chk_sram_write_lands: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(st_r.mem_busy && st_r.mem_write && st_r.mem_is_ram)
		|=> sram_r[$past(st_r.mem_addr[13:0])] == $past(st_r.mem_wdata))
		else $error("sram write did not land");
	chk_unmapped_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(st_r.mem_busy && !st_r.mem_is_reg && !st_r.mem_is_ram) |=> (mem_rdata_out == 8'h00) && !mem_hit_out)
		else $error("unmapped access returned data or hit");
	chk_done_one_pulse: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		mem_done_out |=> !mem_done_out)
		else $error("access done held longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/crf_mul_model.sv
// multiplier partner model feeding the product back to the register file
`default_nettype none
module crf_mul_model (
	input wire logic clk_sys_in, // system clock
	input wire crf_pkg::crf_issue_type issue_in, // issue seen by the file
	input wire logic [7:0] rd_data_in, // first operand
	input wire logic [7:0] rr_data_in, // second operand
	output logic [15:0] product_out // product one cycle after issue
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed_r;
	always_ff @(posedge clk_sys_in)
	begin
		signed_r <= (issue_in.op == crf_pkg::CRF_OP_MUL_RS);
	end
	// operands come from the file's own read ports, so the file sees the product of its own rd and rr contents
	always_comb
	begin
		if (signed_r)
			product_out = {{8{rd_data_in[7]}}, rd_data_in} * {{8{rr_data_in[7]}}, rr_data_in};
		else
			product_out = {8'h00, rd_data_in} * {8'h00, rr_data_in};
	end
endmodule
`default_nettype wire

// >>> tb/tb_crf_top.sv
// self-checking bench for the cpu register file
`default_nettype none
module tb_crf_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 0;
	logic rstn_in = 0;
	crf_pkg::crf_size_type size_in = crf_pkg::CRF_SIZE_16K;
	crf_pkg::crf_issue_type issue_in = '0;
	crf_pkg::crf_mem_type mem_in = '0;
	crf_pkg::crf_flags_type flags_in = '0;
	logic [2:0] bit_sel_in = 3'h0;
	logic [15:0] mul_product_in, p, e;
	logic [7:0] rd_data_out, rr_data_out, mem_rdata_out, d, v, regs [32];
	logic issue_err_out, mem_done_out, mem_hit_out, sign_flag_out, bit_val_out, h;
	logic [2:0] b;
	logic [1:0] f;
	logic [4:0] ra, rb;
	int err_total = 0;
	int tests_run = 0;
	int n;
	crf_top dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .size_in(size_in), .issue_in(issue_in),
		.mul_product_in(mul_product_in), .mem_in(mem_in), .flags_in(flags_in), .bit_sel_in(bit_sel_in),
		.rd_data_out(rd_data_out), .rr_data_out(rr_data_out), .issue_err_out(issue_err_out),
		.mem_rdata_out(mem_rdata_out), .mem_done_out(mem_done_out), .mem_hit_out(mem_hit_out),
		.sign_flag_out(sign_flag_out), .bit_val_out(bit_val_out));
	crf_mul_model mul (.clk_sys_in(clk_sys_in), .issue_in(issue_in), .rd_data_in(rd_data_out),
		.rr_data_in(rr_data_out), .product_out(mul_product_in));
	initial
	begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [15:0] exp_product(input logic sgn, input logic [7:0] a, input logic [7:0] b);
		logic [15:0] wa, wb;
		wa = sgn ? {{8{a[7]}}, a} : {8'h00, a};
		wb = sgn ? {{8{b[7]}}, b} : {8'h00, b};
		return wa * wb;
	endfunction
	task automatic put(input crf_pkg::crf_op_type op, input logic [4:0] rd, input logic [4:0] rr,
		input logic we, input logic [7:0] wd);
		@(posedge clk_sys_in);
		issue_in <= '{op, rd, rr, we, wd};
	endtask
	task automatic idle();
		put(crf_pkg::CRF_OP_NONE, 5'h00, 5'h00, 1'b0, 8'h00);
	endtask
	task automatic wrreg(input logic [4:0] r, input logic [7:0] x);
		put(crf_pkg::CRF_OP_ALU, r, r, 1'b1, x);
		regs[r] = x;
		idle();
	endtask
	task automatic rdreg(input logic [4:0] r, output logic [7:0] x);
		put(crf_pkg::CRF_OP_NONE, r, r, 1'b0, 8'h00);
		idle();
		#1 x = rd_data_out;
	endtask
	task automatic setp(input crf_pkg::crf_ptr_type pt, input logic [15:0] a);
		wrreg(crf_pkg::PTR_X_LO + 5'({pt, 1'b0}), a[7:0]);
		wrreg(crf_pkg::PTR_X_LO + 5'({pt, 1'b1}), a[15:8]);
	endtask
	task automatic acc(input logic w, input crf_pkg::crf_ptr_type pt, input logic [5:0] dp,
		input logic [7:0] wd, output logic [7:0] x, output logic hit);
		int c;
		@(posedge clk_sys_in);
		mem_in <= '{1'b1, w, pt, dp, wd};
		@(posedge clk_sys_in);
		mem_in.valid <= 1'b0;
		#1 c = 1;
		while (mem_done_out !== 1'b1 && c < 6)
		begin
			@(posedge clk_sys_in);
			#1 c++;
		end
		chk("access cycles", 16'(c), 16'(crf_pkg::SRAM_ACCESS_CYCLES));
		x = mem_rdata_out;
		hit = mem_hit_out;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#200000;
		err_total++;
		give_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(18239));
		repeat (9) @(posedge clk_sys_in);
		#1 chk("outputs in reset", {rd_data_out, mem_rdata_out}, 16'h0000);
		@(posedge clk_sys_in);
		rstn_in <= 1'b1;
		for (int i = 0; i < 32; i++)
		begin
			d = 8'($urandom);
			put(crf_pkg::CRF_OP_ALU, 5'(i), 5'(i), 1'b1, d);
			put(crf_pkg::CRF_OP_NONE, 5'(i), 5'(i), 1'b0, 8'h00);
			regs[i] = d;
			idle();
			#1 chk("write then read", rd_data_out, d);
		end
		for (int i = 0; i < 32; i++)
		begin
			put(crf_pkg::CRF_OP_NONE, 5'(i), 5'(31 - i), 1'b0, 8'h00);
			b = 3'($urandom);
			f = 2'($urandom);
			bit_sel_in <= b;
			flags_in <= crf_pkg::crf_flags_type'(f);
			idle();
			#1 chk("rd read", rd_data_out, regs[i]);
			chk("rr read", rr_data_out, regs[31 - i]);
			chk("bit select", bit_val_out, regs[i][b]);
			chk("sign flag", sign_flag_out, f[1] ^ f[0]);
		end
		for (int i = 0; i < 32; i++)
		begin
			d = 8'($urandom);
			put(crf_pkg::CRF_OP_IMM, 5'(i), 5'(i), 1'b1, d);
			idle();
			#1 chk("imm refusal", issue_err_out, 16'(i < 16));
			if (i >= 16)
				regs[i] = d;
			rdreg(5'(i), v);
			chk("imm target", v, regs[i]);
		end
		// operands taken from the result pair itself: r0*r0, then r1*r0; then restricted r16*r16
		for (int k = 0; k < 3; k++)
		begin
			ra = (k == 2) ? 5'h10 : 5'(k);
			rb = (k == 2) ? 5'h10 : 5'h00;
			put(k < 2 ? crf_pkg::CRF_OP_MUL_UU : crf_pkg::CRF_OP_MUL_RS, ra, rb, 1'b0, 8'h00);
			idle();
			p = exp_product(k == 2, regs[ra], regs[rb]);
			#1 chk("mul operand check", issue_err_out, 16'h0000);
			{regs[1], regs[0]} = p;
			rdreg(crf_pkg::MUL_LO, v);
			chk("product low", v, p[7:0]);
			rdreg(crf_pkg::MUL_HI, v);
			chk("product high", v, p[15:8]);
		end
		put(crf_pkg::CRF_OP_MUL_RS, 5'h0f, 5'h11, 1'b0, 8'h00);
		idle();
		#1 chk("signed mul refusal", issue_err_out, 16'h0001);
		rdreg(crf_pkg::MUL_LO, v);
		chk("refused mul keeps pair", v, regs[0]);
		for (int pt = 0; pt < 3; pt++)
		begin
			setp(crf_pkg::crf_ptr_type'(pt), 16'h0000);
			n = $urandom % 26;
			acc(1'b0, crf_pkg::crf_ptr_type'(pt), 6'(n), 8'h00, v, h);
			chk("reg via pointer", {h, v}, {1'b1, regs[n]});
			d = 8'($urandom);
			acc(1'b1, crf_pkg::crf_ptr_type'(pt), 6'(n), d, v, h);
			rdreg(5'(n), v);
			chk("shared storage", v, d);
			acc(1'b0, crf_pkg::crf_ptr_type'(pt), 6'(32 + n), 8'h00, v, h);
			chk("io gap miss", {h, v}, 16'h0000);
			regs[n] = d;
		end
		for (int s = 0; s < 4; s++)
		begin
			e = crf_pkg::SRAM_END_4K + 16'(s) * 16'h1000;
			setp(crf_pkg::CRF_PTR_X, crf_pkg::SRAM_BASE);
			setp(crf_pkg::CRF_PTR_Z, e - 16'h003f);
			setp(crf_pkg::CRF_PTR_Y, e + 16'h0061);
			size_in <= crf_pkg::crf_size_type'(s);
			d = 8'($urandom);
			acc(1'b1, crf_pkg::CRF_PTR_X, 6'h00, d, v, h);
			acc(1'b1, crf_pkg::CRF_PTR_Z, 6'h3f, ~d, v, h);
			acc(1'b1, crf_pkg::CRF_PTR_Y, 6'h00, d ^ 8'h5a, v, h);
			chk("beyond write hit", h, 16'h0000);
			acc(1'b0, crf_pkg::CRF_PTR_Y, 6'h00, 8'h00, v, h);
			chk("beyond read", {h, v}, 16'h0000);
			acc(1'b0, crf_pkg::CRF_PTR_Z, 6'h3f, 8'h00, v, h);
			chk("sram end", {h, v}, {1'b1, ~d});
			acc(1'b0, crf_pkg::CRF_PTR_X, 6'h00, 8'h00, v, h);
			chk("sram base no alias", {h, v}, {1'b1, d});
		end
		give_verdict();
	end
endmodule
`default_nettype wire
